// *** design/hbp_device.sv ***
// Device end: parallel and serial host port with interrupt pin
`timescale 1ns/1ps
module hbp_device
   import hbp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   hbp_if.device pins,
   input wire logic [7:0] status_event,
   input wire logic [7:0] core_rdata,
   output logic [7:0] core_addr,
   output logic [7:0] core_wdata,
   output logic core_wr,
   output logic core_rd,
   output logic [2:0] pulse_shape,
   output logic [7:0] status,
   output logic [7:0] int_enable
);
   localparam int SW = 15;
   logic [SW-1:0] raw;
   logic [SW-1:0] syn;
   logic cs_n_s, ale_s, ds_s, rw_s, hw_s, ser_s, style_s, edge_s;
   logic [7:0] ad_s;

   assign raw = {pins.cs_n, pins.address_strobe_n, pins.data_strobe,
      pins.read_write, pins.ad, pins.hw_mode, pins.serial_mode,
      pins.bus_style_sel};
   hbp_sync #(.WIDTH(SW)) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in(raw),
      .reset_val('1),
      .sync_out(syn)
   );
   assign {cs_n_s, ale_s, ds_s, rw_s, ad_s, hw_s, ser_s, style_s} = syn;

   logic edge_q1, edge_q2;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         edge_q1 <= 1'b0;
         edge_q2 <= 1'b0;
      end
      else
      begin
         edge_q1 <= pins.serial_edge_sel;
         edge_q2 <= edge_q1;
      end
   end
   assign edge_s = edge_q2;

   // Mode decode
   wire host_mode = !hw_s;
   wire mot = host_mode && !ser_s && !style_s;
   wire split = host_mode && !ser_s && style_s;
   wire serial = host_mode && ser_s;
   assign pulse_shape = hw_s ? {ale_s, rw_s, ds_s} : 3'h0;

   // Address latch on strobe falling edge
   logic ale_d;
   logic [7:0] addr_q;
   wire ale_fall = ale_d && !ale_s && !cs_n_s && !serial;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ale_d <= 1'b1;
         addr_q <= 8'h00;
      end
      else
      begin
         ale_d <= ale_s;
         if (ale_fall)
            addr_q <= ad_s;
      end
   end

   // Parallel strobe decode
   wire strobe = mot ? !ds_s : (split && (!ds_s || !rw_s));
   wire is_read = mot ? rw_s : !rw_s;
   wire active = !cs_n_s && strobe;

   hbp_pstate_type pstate;
   logic [7:0] wait_cnt;
   logic [7:0] gap_cnt;
   logic read_q;
   logic [7:0] wdata_q;
   logic [7:0] ad_out_q;
   wire back_to_back = gap_cnt < GAP_CYCLES[7:0];
   wire par_start = pstate == P_IDLE && active;
   wire par_fire = pstate == P_BUSY && wait_cnt == 8'h00;
   wire par_wr = par_fire && !read_q;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pstate <= P_IDLE;
         wait_cnt <= 8'h00;
         gap_cnt <= GAP_CYCLES[7:0];
         read_q <= 1'b0;
         wdata_q <= 8'h00;
      end
      else
      begin
         unique case (pstate)
            P_IDLE:
            begin
               if (!back_to_back)
                  gap_cnt <= gap_cnt;
               else
                  gap_cnt <= gap_cnt + 8'h01;
               if (par_start)
               begin
                  pstate <= P_BUSY;
                  read_q <= is_read;
                  wdata_q <= ad_s;
                  if (!is_read && back_to_back)
                     wait_cnt <= WAIT_CYCLES[7:0];
                  else
                     wait_cnt <= XFER_CYCLES[7:0] - 8'h01;
               end
            end
            P_BUSY:
            begin
               if (wait_cnt == 8'h00)
                  pstate <= P_DONE;
               else
                  wait_cnt <= wait_cnt - 8'h01;
            end
            P_DONE:
            begin
               if (!active)
               begin
                  pstate <= P_IDLE;
                  gap_cnt <= 8'h00;
               end
            end
         endcase
      end
   end

   // Serial frame: command byte {addr[6:0], read} then data, LSB first
   logic sclk_d;
   logic [4:0] bit_cnt;
   logic [15:0] frame_q;
   logic [7:0] ser_addr;
   logic [7:0] ser_wdata;
   logic ser_rd_q, ser_wr_q, ser_read;
   logic [7:0] hold_q;
   logic so_q;
   wire frame_on = serial && !cs_n_s;
   wire sclk_rise = frame_on && !sclk_d && ale_s;
   wire sclk_fall = frame_on && sclk_d && !ale_s;
   wire data_phase = bit_cnt[4:3] == 2'b01;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sclk_d <= 1'b0;
         bit_cnt <= 5'h00;
         frame_q <= 16'h0000;
         ser_addr <= 8'h00;
         ser_wdata <= 8'h00;
         ser_rd_q <= 1'b0;
         ser_wr_q <= 1'b0;
         ser_read <= 1'b0;
         so_q <= 1'b1;
      end
      else
      begin
         sclk_d <= ale_s;
         ser_rd_q <= 1'b0;
         ser_wr_q <= 1'b0;
         if (!frame_on)
            bit_cnt <= 5'h00;
         else if (sclk_rise)
         begin
            frame_q[bit_cnt[3:0]] <= ds_s;
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'h07)
            begin
               ser_addr <= {1'b0, ds_s, frame_q[6:1]};
               ser_read <= frame_q[0];
               ser_rd_q <= frame_q[0];
            end
            if (bit_cnt == 5'h0f)
            begin
               ser_wdata <= {ds_s, frame_q[14:8]};
               ser_wr_q <= !ser_read;
            end
            if (data_phase && !edge_s)
               so_q <= hold_q[bit_cnt[2:0]];
         end
         else if (sclk_fall && data_phase && edge_s)
            so_q <= hold_q[bit_cnt[2:0]];
      end
   end

   // Register access path
   assign core_addr = serial ? ser_addr : addr_q;
   assign core_wdata = serial ? ser_wdata : wdata_q;
   assign core_rd = (par_start && is_read) || ser_rd_q;
   assign core_wr = par_wr || ser_wr_q;
   wire hit_status = core_addr == DEV_STATUS_ADDR;
   wire hit_inten = core_addr == DEV_INTEN_ADDR;
   wire [7:0] rd_data = hit_status ? status :
      (hit_inten ? int_enable : core_rdata);
   wire [7:0] status_clr = (core_wr && hit_status) ? core_wdata : 8'h00;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         status <= DEV_STATUS_RESET;
         int_enable <= DEV_INTEN_RESET;
         ad_out_q <= 8'h00;
         hold_q <= 8'h00;
      end
      else
      begin
         status <= (status & ~status_clr) | status_event;
         if (core_wr && hit_inten)
            int_enable <= core_wdata;
         if (par_start && is_read)
            ad_out_q <= rd_data;
         if (ser_rd_q)
            hold_q <= rd_data;
      end
   end

   // Pin drivers
   wire irq_on = |(status & int_enable);
   assign pins.irq_out = 1'b0;
   assign pins.irq_oe_n = !irq_on;
   assign pins.ad_dev_out = ad_out_q;
   assign pins.ad_dev_oe_n = !(host_mode && !serial && !cs_n_s &&
      read_q && pstate != P_IDLE && strobe);

   wire mot_ack = pstate != P_DONE;
   wire split_rdy = pstate == P_DONE;
   wire ack_drive_mot = mot && !cs_n_s;
   wire ack_drive_split = split && !cs_n_s && pstate != P_IDLE;
   wire ack_drive_ser = frame_on && ser_read && bit_cnt >= 5'h08;
   assign pins.ack_out = mot ? mot_ack : (split ? split_rdy : so_q);
   assign pins.ack_oe_n = !(ack_drive_mot || ack_drive_split ||
      ack_drive_ser);
endmodule : hbp_device

// *** design/hbp_host.sv ***
// Host end: Wishbone-controlled driver of the device pins
`timescale 1ns/1ps
module hbp_host
   import hbp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   hbp_if.host pins,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [7:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_w,
   output logic [31:0] wb_dat_r,
   output logic wb_ack,
   output logic irq_level
);
   logic [9:0] syn;
   logic [7:0] ad_s;
   logic ack_s, irq_s;
   hbp_sync #(.WIDTH(10)) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .async_in({pins.ad, pins.ack_line, pins.irq_line}),
      .reset_val('1),
      .sync_out(syn)
   );
   assign {ad_s, ack_s, irq_s} = syn;
   assign irq_level = !irq_s;

   logic [31:0] cmd, cfg;
   logic [7:0] rdata;
   logic busy, start_pend;
   wire req = wb_cyc && wb_stb && !wb_ack;
   wire wr = req && wb_we;
   wire [31:0] wmask = {{8{wb_sel[3]}}, {8{wb_sel[2]}},
      {8{wb_sel[1]}}, {8{wb_sel[0]}}};
   wire wr_cmd = wr && wb_adr == HOST_CMD_ADDR;
   wire wr_cfg = wr && wb_adr == HOST_CFG_ADDR;
   wire [31:0] cmd_new = (cmd & ~wmask) | (wb_dat_w & wmask);
   wire [31:0] stat_word = {22'h0, irq_level, busy, rdata};
   wire [31:0] rd_mux = wb_adr == HOST_CMD_ADDR ? cmd :
      (wb_adr == HOST_CFG_ADDR ? cfg :
      (wb_adr == HOST_STAT_ADDR ? stat_word : 32'h0));

   wire mot = !cfg[CFG_STYLE_BIT];
   wire ser = cfg[CFG_SERIAL_BIT];
   wire edge_hi = cfg[CFG_EDGE_BIT];
   wire hw = cfg[CFG_HW_BIT];
   wire rd_op = cmd[CMD_READ_BIT];
   wire [7:0] c_addr = cmd[CMD_ADDR_LSB +: 8];
   wire [7:0] c_wdata = cmd[CMD_WDATA_LSB +: 8];
   wire [15:0] frame = {rd_op ? 8'h00 : c_wdata, c_addr[6:0], rd_op};
   assign pins.hw_mode = hw;
   assign pins.serial_mode = ser;
   assign pins.bus_style_sel = cfg[CFG_STYLE_BIT];
   assign pins.serial_edge_sel = edge_hi;

   logic [7:0] div;
   wire tick = div == 8'h00;
   hbp_hstate_type hs;
   logic cs_n, ale, ds, rw, seen_low;
   logic [7:0] ad_out;
   logic ad_oe_n;
   logic [3:0] bitn;
   wire [3:0] bit_nx = bitn + 4'h1;
   wire samp_rise = edge_hi && bitn[3] && rd_op;
   wire samp_fall = !edge_hi && bitn[3] && rd_op;
   wire [2:0] shape = cfg[CFG_SHAPE_LSB +: 3];
   assign pins.cs_n = cs_n;
   assign pins.address_strobe_n = hw ? shape[2] : ale;
   assign pins.read_write = hw ? shape[1] : rw;
   assign pins.data_strobe = hw ? shape[0] : ds;
   assign pins.ad_host_out = ad_out;
   assign pins.ad_host_oe_n = ad_oe_n;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd <= HOST_CMD_RESET;
         cfg <= HOST_CFG_RESET;
         wb_ack <= 1'b0;
         wb_dat_r <= 32'h0;
         start_pend <= 1'b0;
         div <= 8'h00;
      end
      else
      begin
         wb_ack <= req;
         wb_dat_r <= req ? rd_mux : wb_dat_r;
         div <= tick ? HOST_DIV_CYCLES[7:0] - 8'h01 : div - 8'h01;
         if (wr_cmd && !busy)
         begin
            cmd <= cmd_new & ~(32'h1 << CMD_START_BIT);
            start_pend <= cmd_new[CMD_START_BIT];
         end
         else if (hs == H_IDLE && tick)
            start_pend <= 1'b0;
         if (wr_cfg)
            cfg <= (cfg & ~wmask) | (wb_dat_w & wmask);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hs <= H_IDLE;
         cs_n <= 1'b1;
         ale <= 1'b1;
         ds <= 1'b1;
         rw <= 1'b1;
         ad_out <= 8'h00;
         ad_oe_n <= 1'b1;
         seen_low <= 1'b0;
         bitn <= 4'h0;
         busy <= 1'b0;
         rdata <= 8'h00;
      end
      else
      begin
         unique case (hs)
            H_IDLE:
            begin
               busy <= start_pend;
               if (tick && start_pend && !hw)
               begin
                  cs_n <= 1'b0;
                  bitn <= 4'h0;
                  if (ser)
                  begin
                     ale <= 1'b0;
                     ds <= frame[0];
                     hs <= H_SER;
                  end
                  else
                  begin
                     ad_out <= c_addr;
                     ad_oe_n <= 1'b0;
                     hs <= H_ADDR;
                  end
               end
            end
            H_ADDR:
               if (tick)
               begin
                  ale <= 1'b0;
                  hs <= H_LATCH;
               end
            H_LATCH:
               if (tick)
               begin
                  ale <= 1'b1;
                  ad_out <= c_wdata;
                  ad_oe_n <= rd_op;
                  if (mot)
                     rw <= rd_op;
                  hs <= H_STROBE;
               end
            H_STROBE:
               if (tick)
               begin
                  if (mot || !rd_op)
                     ds <= 1'b0;
                  else
                     rw <= 1'b0;
                  seen_low <= 1'b0;
                  hs <= H_WAIT;
               end
            H_WAIT:
            begin
               if (!ack_s)
                  seen_low <= 1'b1;
               if ((mot && !ack_s) || (!mot && seen_low && ack_s))
               begin
                  if (rd_op)
                     rdata <= ad_s;
                  hs <= H_END;
               end
            end
            H_END:
               if (tick)
               begin
                  ds <= 1'b1;
                  rw <= 1'b1;
                  ad_oe_n <= 1'b1;
                  hs <= H_REL;
               end
            H_REL:
               if (tick && ack_s)
               begin
                  cs_n <= 1'b1;
                  busy <= 1'b0;
                  hs <= H_IDLE;
               end
            H_SER:
               if (tick)
               begin
                  if (!ale)
                  begin
                     ale <= 1'b1;
                     if (samp_rise)
                        rdata[bitn[2:0]] <= ack_s;
                  end
                  else
                  begin
                     ale <= 1'b0;
                     if (samp_fall)
                        rdata[bitn[2:0]] <= ack_s;
                     bitn <= bit_nx;
                     ds <= frame[bit_nx];
                     if (bitn == 4'hf)
                     begin
                        cs_n <= 1'b1;
                        ale <= 1'b1;
                        ds <= 1'b1;
                        busy <= 1'b0;
                        hs <= H_IDLE;
                     end
                  end
               end
         endcase
      end
   end
endmodule : hbp_host

// *** design/hbp_if.sv ***
// Pin-level link between the host end and the device end
`timescale 1ns/1ps
interface hbp_if;
   logic cs_n;
   logic address_strobe_n;
   logic data_strobe;
   logic read_write;
   logic [7:0] ad_host_out;
   logic ad_host_oe_n;
   logic [7:0] ad_dev_out;
   logic ad_dev_oe_n;
   logic [7:0] ad;
   logic ack_out;
   logic ack_oe_n;
   logic ack_line;
   logic irq_out;
   logic irq_oe_n;
   logic irq_line;
   logic hw_mode;
   logic serial_mode;
   logic bus_style_sel;
   logic serial_edge_sel;

   // Wire levels; undriven lines are pulled high
   assign ad = !ad_host_oe_n ? ad_host_out :
      (!ad_dev_oe_n ? ad_dev_out : 8'hff);
   assign ack_line = !ack_oe_n ? ack_out : 1'b1;
   assign irq_line = !irq_oe_n ? irq_out : 1'b1;

   modport device (
      input cs_n, address_strobe_n, data_strobe, read_write, ad,
      input hw_mode, serial_mode, bus_style_sel, serial_edge_sel,
      output ad_dev_out, ad_dev_oe_n, ack_out, ack_oe_n,
      output irq_out, irq_oe_n
   );
   modport host (
      output cs_n, address_strobe_n, data_strobe, read_write,
      output ad_host_out, ad_host_oe_n,
      output hw_mode, serial_mode, bus_style_sel, serial_edge_sel,
      input ad, ack_line, irq_line
   );
endinterface : hbp_if

// *** design/hbp_pkg.sv ***
// Shared constants and types for the host bus port, both ends
//
// Overview of operation
// - Interrupt pin active low, open drain, maskable
// - Enabled state change pulls interrupt pin low
// - Host treats interrupt as level sensitive
// - Address-strobe read: acknowledge low means data valid
// - Address-strobe write: acknowledge low after register accepts
// - Wait states only for write after recent cycle
// - Split-strobe: ready low during transfer, high done
// - Split-strobe: ready floats after each bus cycle
// - Serial output valid on edge chosen by select
// - Serial output floats during serial write access
// - Shared strobe pin: data or write strobe
// - Serial mode: serial input on strobe pin
// - Direction pin: read/write select or read strobe
// - Address captured on address strobe falling edge
// - Serial mode: shift clock on address strobe pin
// - Address-strobe mode: address strobe active low
// - Hardware mode: strobe pins select pulse shape
// - Chip select falls and stays low per access
// - Bus style select low address-strobe, high split
package hbp_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int XFER_CYCLES = 1;
   localparam int WAIT_TIME_NS = 500;
   localparam int WAIT_CYCLES = (WAIT_TIME_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int GAP_TIME_NS = 5000;
   localparam int GAP_CYCLES = GAP_TIME_NS / CLK_PERIOD_NS;
   // Host pin step
   localparam int HOST_STEP_NS = 800;
   localparam int HOST_DIV_CYCLES = HOST_STEP_NS / CLK_PERIOD_NS;
   // Device register addresses
   localparam logic [7:0] DEV_STATUS_ADDR = 8'h00;
   localparam logic [7:0] DEV_INTEN_ADDR = 8'h01;
   localparam logic [7:0] DEV_STATUS_RESET = 8'h00;
   localparam logic [7:0] DEV_INTEN_RESET = 8'h00;
   // Host Wishbone registers, byte addresses
   localparam logic [7:0] HOST_CMD_ADDR = 8'h00;
   localparam logic [7:0] HOST_CFG_ADDR = 8'h04;
   localparam logic [7:0] HOST_STAT_ADDR = 8'h08;
   localparam logic [31:0] HOST_CMD_RESET = 32'h0000_0000;
   localparam logic [31:0] HOST_CFG_RESET = 32'h0000_0000;
   // Command fields
   localparam int CMD_ADDR_LSB = 0;
   localparam int CMD_WDATA_LSB = 8;
   localparam int CMD_READ_BIT = 16;
   localparam int CMD_START_BIT = 17;
   // Config fields
   localparam int CFG_STYLE_BIT = 0;
   localparam int CFG_SERIAL_BIT = 1;
   localparam int CFG_EDGE_BIT = 2;
   localparam int CFG_HW_BIT = 3;
   localparam int CFG_SHAPE_LSB = 4;
   // Status fields
   localparam int STAT_BUSY_BIT = 8;
   localparam int STAT_IRQ_BIT = 9;
   localparam int SER_FRAME_BITS = 16;

   typedef enum logic [1:0] {
      P_IDLE = 2'b00,
      P_BUSY = 2'b01,
      P_DONE = 2'b10
   } hbp_pstate_type;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_ADDR = 3'b001,
      H_LATCH = 3'b010,
      H_STROBE = 3'b011,
      H_WAIT = 3'b100,
      H_END = 3'b101,
      H_REL = 3'b110,
      H_SER = 3'b111
   } hbp_hstate_type;
endpackage : hbp_pkg

// *** design/hbp_sync.sv ***
// Two-flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module hbp_sync #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   input wire logic [WIDTH-1:0] reset_val,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1 <= '1;
         sync_out <= '1;
      end
      else
      begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : hbp_sync

// *** verif/hbp_checker.sv ***
// Pin-level assertions for the host bus port link
`timescale 1ns/1ps
module hbp_checker (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic address_strobe_n,
   input wire logic data_strobe,
   input wire logic read_write,
   input wire logic ad_dev_oe_n,
   input wire logic ack_out,
   input wire logic ack_oe_n,
   input wire logic ack_line,
   input wire logic irq_out,
   input wire logic irq_oe_n,
   input wire logic irq_line,
   input wire logic hw_mode,
   input wire logic serial_mode,
   input wire logic bus_style_sel,
   input wire logic serial_edge_sel
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire par0 = !hw_mode && !serial_mode && !bus_style_sel;
   wire par1 = !hw_mode && !serial_mode && bus_style_sel;
   wire ser = !hw_mode && serial_mode;
   logic as_q;
   logic frame_rd;
   logic [4:0] sclk_cnt;
   wire sclk_rise = address_strobe_n && !as_q;
   // Frame tracker: shift clock rises and read flag
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         as_q <= 1'b1;
         frame_rd <= 1'b0;
         sclk_cnt <= 5'h00;
      end
      else
      begin
         as_q <= address_strobe_n;
         if (cs_n)
         begin
            frame_rd <= 1'b0;
            sclk_cnt <= 5'h00;
         end
         else if (sclk_rise)
         begin
            sclk_cnt <= sclk_cnt + 5'h01;
            if (sclk_cnt == 5'h00)
               frame_rd <= data_strobe;
         end
      end
   end
   sequence ack_answer;
      ack_line [*2] ##[1:12] !ack_line;
   endsequence
   sequence rdy_cycle;
      ##[1:8] !ack_line ##[1:12] ack_line;
   endsequence
   chk_irq_open_drain: assert property (!irq_oe_n |-> !irq_out)
      else $error("interrupt pin driven high");
   chk_irq_level_hold: assert property ($fell(irq_line) |-> !irq_line [*8])
      else $error("interrupt released too soon");
   chk_ack_wait_bound: assert property (par0 && $fell(data_strobe) |-> ack_answer)
      else $error("acknowledge timing wrong");
   chk_ack_strobe_up: assert property (par0 && data_strobe [*6] |-> ack_line)
      else $error("acknowledge low without strobe");
   chk_read_data_driven: assert property (par0 && !cs_n && read_write && !data_strobe && !ack_line |-> !ad_dev_oe_n)
      else $error("read acknowledged without data");
   chk_ready_busy_done: assert property (par1 && ($fell(data_strobe) || $fell(read_write)) |-> rdy_cycle)
      else $error("ready sequence wrong");
   chk_idle_float: assert property (!hw_mode && cs_n [*6] |-> ack_oe_n)
      else $error("acknowledge pin driven while idle");
   chk_ser_write_float: assert property (ser && !cs_n && !frame_rd |-> ack_oe_n)
      else $error("serial output driven in write frame");
   chk_ser_edge_rise: assert property (ser && serial_edge_sel && !ack_oe_n && $rose(address_strobe_n) && sclk_cnt < 5'd15 |-> $stable(ack_out) [*4])
      else $error("serial output moves at rising edge");
   chk_ser_edge_fall: assert property (ser && !serial_edge_sel && !ack_oe_n && $fell(address_strobe_n) && sclk_cnt < 5'd16 |-> $stable(ack_out) [*4])
      else $error("serial output moves at falling edge");
endmodule : hbp_checker

// *** verif/host_bus_port_pins_bench.sv ***
// Testbench joining host end and device end over the pin link
`timescale 1ns/1ps
module host_bus_port_pins_bench;
   import hbp_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_dat_w = 32'h0;
   logic [31:0] wb_dat_r;
   logic wb_ack;
   logic irq_level;
   logic [7:0] status_event = 8'h00;
   logic [7:0] core_rdata;
   logic [7:0] core_addr;
   logic [7:0] core_wdata;
   logic core_wr;
   logic core_rd;
   logic [2:0] pulse_shape;
   logic [7:0] status;
   logic [7:0] int_enable;
   logic [7:0] wr_addr = 8'h00;
   logic [7:0] wr_data = 8'h00;
   logic [7:0] q;
   logic [7:0] e;
   logic [31:0] s;
   logic [2:0] mode_cfg [4] = '{3'b000, 3'b001, 3'b110, 3'b010};
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0;
   always #50 sys_clk = ~sys_clk;
   assign core_rdata = core_addr ^ 8'h5a;
   hbp_if hbp_if_inst ();
   hbp_device hbp_device_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .pins(hbp_if_inst.device), .status_event(status_event),
      .core_rdata(core_rdata), .core_addr(core_addr),
      .core_wdata(core_wdata), .core_wr(core_wr), .core_rd(core_rd),
      .pulse_shape(pulse_shape), .status(status), .int_enable(int_enable));
   hbp_host hbp_host_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .pins(hbp_if_inst.host), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
      .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
      .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .irq_level(irq_level));
   hbp_checker hbp_checker_inst (.sys_clk(sys_clk), .rst_n(rst_n),
      .cs_n(hbp_if_inst.cs_n), .address_strobe_n(hbp_if_inst.address_strobe_n),
      .data_strobe(hbp_if_inst.data_strobe),
      .read_write(hbp_if_inst.read_write),
      .ad_dev_oe_n(hbp_if_inst.ad_dev_oe_n), .ack_out(hbp_if_inst.ack_out),
      .ack_oe_n(hbp_if_inst.ack_oe_n), .ack_line(hbp_if_inst.ack_line),
      .irq_out(hbp_if_inst.irq_out), .irq_oe_n(hbp_if_inst.irq_oe_n),
      .irq_line(hbp_if_inst.irq_line), .hw_mode(hbp_if_inst.hw_mode),
      .serial_mode(hbp_if_inst.serial_mode),
      .bus_style_sel(hbp_if_inst.bus_style_sel),
      .serial_edge_sel(hbp_if_inst.serial_edge_sel));
   always @(posedge sys_clk)
   begin
      if (core_wr === 1'b1)
      begin
         wr_addr <= core_addr;
         wr_data <= core_wdata;
      end
   end
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         mismatches++;
         report_and_stop();
      end
   end
   task report_and_stop();
      $display("Checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop
   task check(input string name, input logic [31:0] exp,
      input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask : check
   task wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge sys_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_sel <= 4'hf;
      wb_dat_w <= d;
      do @(posedge sys_clk); while (wb_ack !== 1'b1);
      r = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : wb_xfer
   task dev_cmd(input logic [7:0] a, input logic [7:0] d, input logic rd,
      output logic [7:0] r);
      logic [31:0] c;
      logic [31:0] t;
      c = 32'h0;
      c[CMD_ADDR_LSB +: 8] = a;
      c[CMD_WDATA_LSB +: 8] = d;
      c[CMD_READ_BIT] = rd;
      c[CMD_START_BIT] = 1'b1;
      wb_xfer(1'b1, HOST_CMD_ADDR, c, t);
      repeat (HOST_DIV_CYCLES + 2) @(posedge sys_clk);
      t = 32'hffff_ffff;
      while (t[STAT_BUSY_BIT] !== 1'b0)
         wb_xfer(1'b0, HOST_STAT_ADDR, 32'h0, t);
      r = t[7:0];
   endtask : dev_cmd
   task set_cfg(input logic [2:0] m, input logic hw, input logic [2:0] shp);
      logic [31:0] c;
      logic [31:0] t;
      c = 32'h0;
      c[CFG_STYLE_BIT] = m[0];
      c[CFG_SERIAL_BIT] = m[1];
      c[CFG_EDGE_BIT] = m[2];
      c[CFG_HW_BIT] = hw;
      c[CFG_SHAPE_LSB +: 3] = shp;
      wb_xfer(1'b1, HOST_CFG_ADDR, c, t);
      wb_xfer(1'b0, HOST_CFG_ADDR, 32'h0, t);
      check("cfg", c, t);
      repeat (6) @(posedge sys_clk);
   endtask : set_cfg
   task pulse_event(input logic [7:0] v);
      @(posedge sys_clk);
      status_event <= v;
      @(posedge sys_clk);
      status_event <= 8'h00;
      repeat (8) @(posedge sys_clk);
   endtask : pulse_event
   initial
   begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      check("status", {24'h0, DEV_STATUS_RESET}, {24'h0, status});
      check("int_enable", {24'h0, DEV_INTEN_RESET}, {24'h0, int_enable});
      check("ack_oe_n", 32'h1, {31'h0, hbp_if_inst.ack_oe_n});
      wb_xfer(1'b0, HOST_CFG_ADDR, 32'h0, s);
      check("cfg_reset", HOST_CFG_RESET, s);
      wb_xfer(1'b0, HOST_CMD_ADDR, 32'h0, s);
      check("cmd_reset", HOST_CMD_RESET, s);
      wb_xfer(1'b0, 8'h0c, 32'h0, s);
      check("unmapped", 32'h0, s);
      $display("Test reset done");
      for (int i = 0; i < 4; i++)
      begin
         set_cfg(mode_cfg[i], 1'b0, 3'b000);
         e = 8'ha0 + 8'(i);
         dev_cmd(DEV_INTEN_ADDR, e, 1'b0, q);
         check("int_enable", {24'h0, e}, {24'h0, int_enable});
         dev_cmd(DEV_INTEN_ADDR, 8'h00, 1'b1, q);
         check("inten_read", {24'h0, e}, {24'h0, q});
         dev_cmd(8'h20, 8'h00, 1'b1, q);
         check("core_read", 32'h7a, {24'h0, q});
         dev_cmd(8'h40 + 8'(i), ~e, 1'b0, q);
         check("core_addr", 32'h40 + i, {24'h0, wr_addr});
         check("core_data", {24'h0, ~e}, {24'h0, wr_data});
         $display("Test mode %0d done", i);
      end
      set_cfg(3'b000, 1'b0, 3'b000);
      dev_cmd(DEV_INTEN_ADDR, 8'h04, 1'b0, q);
      pulse_event(8'h01);
      check("status", 32'h01, {24'h0, status});
      check("irq_masked", 32'h0, {31'h0, irq_level});
      pulse_event(8'h04);
      check("irq_level", 32'h1, {31'h0, irq_level});
      check("irq_line", 32'h0, {31'h0, hbp_if_inst.irq_line});
      dev_cmd(DEV_STATUS_ADDR, 8'h01, 1'b0, q);
      check("irq_kept", 32'h1, {31'h0, irq_level});
      dev_cmd(DEV_STATUS_ADDR, 8'h04, 1'b0, q);
      repeat (8) @(posedge sys_clk);
      check("irq_clear", 32'h0, {31'h0, irq_level});
      check("status_clear", 32'h0, {24'h0, status});
      $display("Test interrupt done");
      for (int i = 0; i < 2; i++)
      begin
         set_cfg(3'b000, 1'b1, i == 0 ? 3'b101 : 3'b010);
         check("pulse_shape", i == 0 ? 32'h5 : 32'h2,
            {29'h0, pulse_shape});
      end
      set_cfg(3'b000, 1'b0, 3'b000);
      $display("Test hardware mode done");
      report_and_stop();
   end
endmodule : host_bus_port_pins_bench
